// ### hdl/link_ctrl_pkg.sv
// constants, register map and state codes for the transmit link layer control
// assumes one lane octet per core clock and an outside framer that marks frame ends
package link_ctrl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_SYNC_PACK = 8'h02;
    localparam logic [7:0] REG_TEST_FRAME = 8'h03;
    localparam logic [7:0] REG_ALIGN_DELAY = 8'h04;
    localparam logic [7:0] RST_SYNC_PACK = 8'h00;
    localparam logic [7:0] RST_TEST_FRAME = 8'h04;
    localparam logic [7:0] RST_ALIGN_DELAY = 8'h00;
    localparam logic [7:0] MASK_SYNC_PACK = 8'hCF;
    localparam logic [7:0] MASK_ALIGN_DELAY = 8'h03;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SYNC_VAL_BIT = 7;
    localparam int SYNC_EN_BIT = 6;
    localparam int PACK_LSB = 2;
    localparam int FRAME_LOW_LSB = 0;
    localparam int PATTERN_LSB = 5;
    localparam int RPAT_FLIP_BIT = 4;
    localparam int MF_CLEAR_BIT = 3;
    localparam int FRAME_MID_BIT = 2;
    localparam int FRAME_HIGH_BIT = 1;
    localparam int RAMP_BIT = 0;
    localparam int DELAY_LSB = 0;

    // ------------------------------------------------------------
    // codes and characters
    // ------------------------------------------------------------
    localparam logic [1:0] PACK_14 = 2'h0;
    localparam logic [1:0] PACK_12 = 2'h3;
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_D21_5 = 3'h1;
    localparam logic [2:0] PAT_K28_5 = 3'h2;
    localparam logic [2:0] PAT_ILA_LOOP = 3'h3;
    localparam logic [2:0] PAT_RANDOM = 3'h4;
    localparam logic [7:0] CHAR_K28_5 = 8'hBC;
    localparam logic [7:0] CHAR_D21_5 = 8'hB5;
    localparam logic [7:0] CHAR_K28_0 = 8'h1C;
    localparam logic [7:0] CHAR_K28_3 = 8'h7C;

    // ------------------------------------------------------------
    // counts
    // ------------------------------------------------------------
    localparam int FRAMES_PER_MF = 5;
    localparam int ILA_MULTIFRAMES = 4;
    localparam int RPAT_LEN = 12;

    typedef enum logic [3:0] {
        ST_SYNC = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_ILA = 4'b0100,
        ST_DATA = 4'b1000
    } link_state_e;

endpackage

// ### hdl/wrap_counter.sv
// modulo counter with a wrap flag
// assumes step and clear are synchronous to the clock
`timescale 1ns/100ps
module wrap_counter #(
    parameter int WIDTH = 4,
    parameter int MODULUS = 5
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_step,
    output logic [WIDTH-1:0] o_count,
    output logic o_wrap
);

    localparam logic [WIDTH-1:0] LAST = WIDTH'(MODULUS - 1);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    assign o_wrap = i_step && (count_r == LAST);
    assign o_count = count_r;

    always_comb begin
        count_nxt = count_r;
        if (i_clear) begin
            count_nxt = '0;
        end else if (o_wrap) begin
            count_nxt = '0;
        end else if (i_step) begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            count_r <= '0;
        end else if (i_ce) begin
            count_r <= count_nxt;
        end
    end

endmodule

// ### hdl/serial_link_layer_control.sv
// transmit link layer control: sync handling, alignment start, test patterns
// assumes one octet per clock, a tick on each frame's last octet and an 8b/10b encoder after
// Behaviour
// (RULE1) override on with value bit set: lane carries K28.5 instead of data
// (RULE2) override enable set: sync request comes from register, pin ignored
// (RULE3) packing 00 gives 14-bit output, 11 gives 12-bit packing
// (RULE4) three frame-assembly controls together select the frame layout
// (RULE5) pattern 000 data, 001 D21.5, 010 continuous K28.5
// (RULE6) pattern 011 loops K28.5 plus alignment; 100 sends 12-octet random pattern
// (RULE7) disparity flip acts only with random pattern selected
// (RULE8) ramp bit replaces data with a ramp, only in 12-bit configuration
// (RULE9) alignment start waits 0 to 3 multiframes after sync release
// (RULE10) a multiframe holds five frames
// (RULE11) software writes zero to reserved bits
// (RULE12) override off: follow active-low pin, K28.5 while asserted
`timescale 1ns/100ps
module serial_link_layer_control #(
    parameter logic [95:0] RPAT_SEQ = 96'hBED723476B8FB3145EFB3559
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic i_sync_request_pin_n,
    input wire logic i_frame_tick,
    input wire logic [7:0] i_data_octet,
    output logic [7:0] o_lane_octet,
    output logic o_lane_is_k,
    output logic o_rd_flip,
    output logic o_pack_12bit,
    output logic [3:0] o_frame_assembly_sel,
    output logic o_ila_active
);
    import link_ctrl_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] sync_pack_r, sync_pack_nxt;
    logic [7:0] test_frame_r, test_frame_nxt;
    logic [7:0] align_dly_r, align_dly_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        sync_pack_nxt = sync_pack_r;
        test_frame_nxt = test_frame_r;
        align_dly_nxt = align_dly_r;
        rdata_nxt = rdata_r;
        // reserved bits are not stored, so they read zero whatever was written
        if (i_reg_wr) begin
            if (i_reg_addr == REG_SYNC_PACK) begin
                sync_pack_nxt = i_reg_wdata & MASK_SYNC_PACK;
            end else if (i_reg_addr == REG_TEST_FRAME) begin
                test_frame_nxt = i_reg_wdata;
            end else if (i_reg_addr == REG_ALIGN_DELAY) begin
                align_dly_nxt = i_reg_wdata & MASK_ALIGN_DELAY;
            end
        end
        if (i_reg_rd) begin
            if (i_reg_addr == REG_SYNC_PACK) begin
                rdata_nxt = sync_pack_r;
            end else if (i_reg_addr == REG_TEST_FRAME) begin
                rdata_nxt = test_frame_r;
            end else if (i_reg_addr == REG_ALIGN_DELAY) begin
                rdata_nxt = align_dly_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_pack_r <= RST_SYNC_PACK;
            test_frame_r <= RST_TEST_FRAME;
            align_dly_r <= RST_ALIGN_DELAY;
            rdata_r <= 8'h00;
        end else if (i_ce) begin
            sync_pack_r <= sync_pack_nxt;
            test_frame_r <= test_frame_nxt;
            align_dly_r <= align_dly_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic sync_en, sync_val, sync_req, ramp_cfg, mf_clear;
    logic [1:0] pack_sel, delay_sel;
    logic [2:0] pattern;

    assign sync_en = sync_pack_r[SYNC_EN_BIT];
    assign sync_val = sync_pack_r[SYNC_VAL_BIT];
    assign pack_sel = sync_pack_r[PACK_LSB +: 2];
    assign pattern = test_frame_r[PATTERN_LSB +: 3];
    assign mf_clear = test_frame_r[MF_CLEAR_BIT];
    assign delay_sel = align_dly_r[DELAY_LSB +: 2];
    // (RULE2) override takes the request
    // (RULE12) else the active-low pin
    assign sync_req = sync_en ? sync_val : !i_sync_request_pin_n;
    // (RULE3) packing decode; 01 and 10 stay 14-bit
    assign o_pack_12bit = (pack_sel == PACK_12);
    // (RULE4) combined frame-assembly select
    assign o_frame_assembly_sel = {test_frame_r[FRAME_HIGH_BIT], test_frame_r[FRAME_MID_BIT],
                                   sync_pack_r[FRAME_LOW_LSB +: 2]};
    // (RULE7) flip gated by random pattern
    assign o_rd_flip = test_frame_r[RPAT_FLIP_BIT] && (pattern == PAT_RANDOM);
    // (RULE8) ramp only in the 12-bit configuration
    assign ramp_cfg = test_frame_r[RAMP_BIT] && o_pack_12bit;

    // ------------------------------------------------------------
    // multiframe timing
    // ------------------------------------------------------------
    logic mf_end;
    logic [2:0] frame_idx;

    // (RULE10) five frames per multiframe
    wrap_counter #(
        .WIDTH(3),
        .MODULUS(FRAMES_PER_MF)
    ) u_frame_in_mf (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_clear(mf_clear),
        .i_step(i_frame_tick),
        .o_count(frame_idx),
        .o_wrap(mf_end)
    );

    // ------------------------------------------------------------
    // link state machine
    // ------------------------------------------------------------
    link_state_e state_r, state_nxt;
    logic [1:0] dly_cnt_r, dly_cnt_nxt;
    logic [1:0] ila_cnt_r, ila_cnt_nxt;
    logic mf_start_r, mf_start_nxt;

    always_comb begin
        state_nxt = state_r;
        dly_cnt_nxt = dly_cnt_r;
        ila_cnt_nxt = ila_cnt_r;
        mf_start_nxt = mf_end;
        case (state_r)
            ST_SYNC: begin
                // (RULE12) release starts the alignment wait
                if (!sync_req) begin
                    state_nxt = ST_DELAY;
                    dly_cnt_nxt = delay_sel;
                end
            end
            ST_DELAY: begin
                if (sync_req) begin
                    state_nxt = ST_SYNC;
                end else if (mf_end) begin
                    // (RULE9) skip the chosen number of multiframes
                    if (dly_cnt_r == 2'h0) begin
                        state_nxt = ST_ILA;
                        ila_cnt_nxt = 2'h0;
                    end else begin
                        dly_cnt_nxt = dly_cnt_r - 2'h1;
                    end
                end
            end
            ST_ILA: begin
                if (sync_req) begin
                    state_nxt = ST_SYNC;
                end else if (mf_end) begin
                    ila_cnt_nxt = ila_cnt_r + 2'h1;
                    if (ila_cnt_r == 2'(ILA_MULTIFRAMES - 1)) begin
                        // (RULE6) loop pattern returns through K28.5
                        state_nxt = (pattern == PAT_ILA_LOOP) ? ST_SYNC : ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                // (RULE1) request forces K28.5 again
                if (sync_req || pattern == PAT_ILA_LOOP) begin
                    state_nxt = ST_SYNC;
                end
            end
            default: begin
                state_nxt = ST_SYNC;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_SYNC;
            dly_cnt_r <= 2'h0;
            ila_cnt_r <= 2'h0;
            mf_start_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            dly_cnt_r <= dly_cnt_nxt;
            ila_cnt_r <= ila_cnt_nxt;
            mf_start_r <= mf_start_nxt;
        end
    end

    assign o_ila_active = (state_r == ST_ILA);

    // ------------------------------------------------------------
    // lane octet selection
    // ------------------------------------------------------------
    logic [7:0] octet_r, octet_nxt;
    logic is_k_r, is_k_nxt;
    logic [3:0] rpat_idx_r, rpat_idx_nxt;
    logic [7:0] ramp_r, ramp_nxt;

    always_comb begin
        octet_nxt = i_data_octet;
        is_k_nxt = 1'b0;
        rpat_idx_nxt = 4'h0;
        ramp_nxt = ramp_r;
        // fixed patterns override the link state so a receiver sees them at once
        if (pattern == PAT_D21_5) begin
            // (RULE5) high-frequency pattern
            octet_nxt = CHAR_D21_5;
        end else if (pattern == PAT_K28_5) begin
            // (RULE5) mixed-frequency pattern
            octet_nxt = CHAR_K28_5;
            is_k_nxt = 1'b1;
        end else if (pattern == PAT_RANDOM) begin
            // (RULE6) twelve octets repeated
            octet_nxt = RPAT_SEQ[8*(RPAT_LEN-1-int'(rpat_idx_r)) +: 8];
            rpat_idx_nxt = (rpat_idx_r == 4'(RPAT_LEN - 1)) ? 4'h0 : rpat_idx_r + 4'h1;
        end else if (state_r == ST_SYNC || state_r == ST_DELAY) begin
            // (RULE1) K28.5 replaces data during sync
            octet_nxt = CHAR_K28_5;
            is_k_nxt = 1'b1;
        end else if (state_r == ST_ILA) begin
            is_k_nxt = mf_start_r || mf_end;
            octet_nxt = mf_end ? CHAR_K28_3 : (mf_start_r ? CHAR_K28_0 : {5'h00, frame_idx});
        end else if (ramp_cfg) begin
            // (RULE8) ramp replaces converter data
            octet_nxt = ramp_r;
            ramp_nxt = ramp_r + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            octet_r <= CHAR_K28_5;
            is_k_r <= 1'b1;
            rpat_idx_r <= 4'h0;
            ramp_r <= 8'h00;
        end else if (i_ce) begin
            octet_r <= octet_nxt;
            is_k_r <= is_k_nxt;
            rpat_idx_r <= rpat_idx_nxt;
            ramp_r <= ramp_nxt;
        end
    end

    assign o_lane_octet = octet_r;
    assign o_lane_is_k = is_k_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb_core @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_release; i_ce && state_r == ST_SYNC && !sync_req; endsequence
    sequence s_sync_hold; i_ce && sync_req && pattern == PAT_NORMAL; endsequence
    AST_OVERRIDE_K: assert property (s_sync_hold ##1 (i_ce && pattern == PAT_NORMAL) // RULE1
        |=> o_lane_octet == CHAR_K28_5 && o_lane_is_k) else $error("no K28.5 under sync");
    AST_PIN_IGNORED: assert property ((i_ce && sync_en && !i_sync_request_pin_n // RULE2
        && !sync_val && state_r == ST_SYNC) |=> state_r == ST_DELAY) else $error("pin not ignored");
    AST_PACKING: assert property (o_pack_12bit == (pack_sel == 2'h3)) // RULE3
        else $error("packing decode wrong");
    AST_FRAME_SEL: assert property ((i_ce && i_reg_wr && i_reg_addr == REG_TEST_FRAME) // RULE4
        |=> o_frame_assembly_sel[3:2] == {$past(i_reg_wdata[1]), $past(i_reg_wdata[2])})
        else $error("frame select not updated");
    AST_D21: assert property ((i_ce && pattern == PAT_D21_5) |=> o_lane_octet == 8'hB5 // RULE5
        && !o_lane_is_k) else $error("D21.5 pattern wrong");
    AST_RPAT_WRAP: assert property ((i_ce && pattern == PAT_RANDOM && rpat_idx_r == 4'hB) // RULE6
        |=> (!i_ce || rpat_idx_r == 4'h0)) else $error("random pattern length wrong");
    AST_FLIP_GATE: assert property (o_rd_flip |-> test_frame_r[7:5] == 3'h4 // RULE7
        && test_frame_r[4]) else $error("disparity flip outside random mode");
    AST_RAMP_STEP: assert property ((i_ce && state_r == ST_DATA && ramp_cfg // RULE8
        && pattern == PAT_NORMAL) |=> o_lane_octet == $past(ramp_r)) else $error("no ramp");
    AST_RELEASE: assert property (s_release |=> state_r == ST_DELAY // RULE12
        && dly_cnt_r == $past(delay_sel)) else $error("release did not start delay");
    AST_DELAY_ZERO: assert property ((i_ce && state_r == ST_DELAY && !sync_req && mf_end // RULE9
        && dly_cnt_r == 2'h0) |=> state_r == ST_ILA) else $error("alignment did not start");
    AST_MF_FIVE: assert property ((i_ce && mf_end) |-> frame_idx == 3'h4 // RULE10
        ##1 frame_idx == 3'h0) else $error("multiframe length not five");
    AST_MF_HOLD: assert property ((i_ce && mf_clear) |=> frame_idx == 3'h0) // RULE10
        else $error("frame counter not held by clear");
endmodule

// ### sim/sync_receiver_model.sv
// far-end receiver model driving the active-low sync request pin
// assumes the bench raises i_hold whenever it wants a fresh code group sync
`timescale 1ns/100ps
module sync_receiver_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_hold,
    input wire logic [7:0] i_lane_octet,
    input wire logic i_lane_is_k,
    output logic o_sync_request_pin_n
);
    import link_ctrl_pkg::*;
    // ------------------------------------------------------------
    // code group lock
    // ------------------------------------------------------------
    logic [2:0] k_run_r;
    logic lock_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            k_run_r <= 3'h0;
            lock_r <= 1'b0;
        end else begin
            if (i_lane_is_k && i_lane_octet == CHAR_K28_5) begin
                k_run_r <= (k_run_r == 3'h4) ? 3'h4 : k_run_r + 3'h1;
            end else begin
                k_run_r <= 3'h0;
            end
            lock_r <= (k_run_r == 3'h4) || (lock_r && !i_hold);
        end
    end
    // request until locked
    // combinational so the bench can place the release on an exact edge
    assign o_sync_request_pin_n = lock_r && !i_hold;
endmodule

// ### sim/serial_link_layer_control_tb.sv
// self-checking bench for the transmit link layer control
// assumes one frame every four octets and the receiver model on the sync pin
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[ERR] %s expected %0h seen %0h", nm, (e), (g)); \
    end \
end
module serial_link_layer_control_tb;
    import link_ctrl_pkg::*;
    localparam logic [95:0] RPAT_EXP = 96'hBED723476B8FB3145EFB3559;
    logic i_core_clk, i_rst, reg_wr, reg_rd, frame_tick, mf_end, hold, sync_pin_n;
    logic lane_is_k, rd_flip, pack_12bit, ila_active, ce;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, data_octet, lane_octet, prev;
    logic [3:0] frame_sel;
    logic [1:0] frame_phase;
    int tick_idx, fails, checked;

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    serial_link_layer_control u_dut (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(ce),
        .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata),
        .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata),
        .i_sync_request_pin_n(sync_pin_n),
        .i_frame_tick(frame_tick),
        .i_data_octet(data_octet),
        .o_lane_octet(lane_octet),
        .o_lane_is_k(lane_is_k),
        .o_rd_flip(rd_flip),
        .o_pack_12bit(pack_12bit),
        .o_frame_assembly_sel(frame_sel),
        .o_ila_active(ila_active)
    );

    sync_receiver_model u_rx (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_hold(hold),
        .i_lane_octet(lane_octet),
        .i_lane_is_k(lane_is_k),
        .o_sync_request_pin_n(sync_pin_n)
    );

    // ------------------------------------------------------------
    // framing stimulus
    // ------------------------------------------------------------
    // data steps by 35h so a ramp can never be mistaken for it
    always @(negedge i_core_clk) begin
        if (!i_rst) begin
            frame_phase <= frame_phase + 2'h1;
            frame_tick <= (frame_phase == 2'h3);
            mf_end <= (frame_phase == 2'h3) && (tick_idx % 5 == 4);
            if (frame_phase == 2'h3) begin
                tick_idx <= tick_idx + 1;
            end
            data_octet <= data_octet + 8'h35;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // a spare cycle after each access keeps strobes from toggling twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        d = reg_rdata;
        cyc(1);
    endtask

    task automatic wait_ila(input logic lvl, output logic hit);
        hit = 1'b0;
        for (int k = 0; k < 400 && !hit; k++) begin
            cyc(1);
            hit = (ila_active === lvl);
        end
    endtask

    task automatic wait_data;
        logic hit;
        wait_ila(1'b1, hit);
        wait_ila(1'b0, hit);
        cyc(2);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset values, packing, frame select, reserved bits
    task automatic t_regs;
        logic [7:0] v;
        rd(8'h02, v);
        `CHK("reg2 reset", 8'h00, v)
        rd(8'h03, v);
        `CHK("reg3 reset", 8'h04, v)
        rd(8'h04, v);
        `CHK("reg4 reset", 8'h00, v)
        `CHK("frame sel reset", 4'b0100, frame_sel)
        `CHK("flip reset", 1'b0, rd_flip)
        wr(8'h02, 8'h3F);
        rd(8'h02, v);
        `CHK("reg2 reserved", 8'h0F, v)
        `CHK("pack 11", 1'b1, pack_12bit)
        `CHK("frame sel", 4'b0111, frame_sel)
        wr(8'h03, 8'h02);
        `CHK("frame sel high", 4'b1011, frame_sel)
        wr(8'h04, 8'hFF);
        rd(8'h04, v);
        `CHK("reg4 reserved", 8'h03, v)
        wr(8'h02, 8'h04);
        `CHK("pack 01", 1'b0, pack_12bit)
        wr(8'h02, 8'h08);
        `CHK("pack 10", 1'b0, pack_12bit)
        wr(8'h05, 8'hFF);
        rd(8'h05, v);
        `CHK("unmapped", 8'h00, v)
        wr(8'h02, 8'h00);
        `CHK("pack 00", 1'b0, pack_12bit)
        wr(8'h03, 8'h04);
    endtask

    // alignment start delay and sequence length
    task automatic t_align(input logic [1:0] d);
        int ends;
        int k3;
        hold = 1'b1;
        wr(8'h04, {6'h00, d});
        cyc(8);
        `CHK("sync octet", {2'b10, CHAR_K28_5}, {lane_is_k, ila_active, lane_octet})
        for (int k = 0; k < 100 && mf_end !== 1'b1; k++) begin
            cyc(1);
        end
        // release right after a multiframe end so the count is exact
        hold = 1'b0;
        ends = 0;
        for (int k = 0; k < 300 && ila_active !== 1'b1; k++) begin
            cyc(1);
            ends += int'(mf_end === 1'b1);
        end
        `CHK("delay ends", int'(d) + 1, ends)
        `CHK("start on end", 1'b1, mf_end)
        ends = 0;
        k3 = 0;
        for (int k = 0; k < 300 && ila_active === 1'b1; k++) begin
            cyc(1);
            ends += int'(mf_end === 1'b1);
            k3 += int'({lane_is_k, lane_octet} === {1'b1, CHAR_K28_3});
        end
        cyc(1);
        k3 += int'({lane_is_k, lane_octet} === {1'b1, CHAR_K28_3});
        `CHK("ila length", ILA_MULTIFRAMES, ends)
        `CHK("ila markers", ILA_MULTIFRAMES, k3)
        cyc(1);
        `CHK("data", {1'b0, data_octet}, {lane_is_k, lane_octet})
    endtask

    task automatic t_override;
        logic hit;
        wr(8'h02, 8'h80);
        cyc(2);
        `CHK("value alone", 1'b0, lane_is_k)
        wr(8'h02, 8'hC0);
        cyc(2);
        `CHK("forced sync", {2'b10, CHAR_K28_5}, {lane_is_k, ila_active, lane_octet})
        hold = 1'b1;
        wr(8'h02, 8'h40);
        wait_ila(1'b1, hit);
        `CHK("pin ignored", 1'b1, hit)
        wr(8'h02, 8'h00);
        cyc(2);
        `CHK("pin followed", {2'b10, CHAR_K28_5}, {lane_is_k, ila_active, lane_octet})
        hold = 1'b0;
        wait_data;
    endtask

    task automatic t_patterns;
        logic hit;
        int idx;
        wr(8'h03, {PAT_D21_5, 5'h14});
        cyc(2);
        `CHK("d21.5", {2'b00, CHAR_D21_5}, {lane_is_k, rd_flip, lane_octet})
        wr(8'h03, {PAT_K28_5, 5'h04});
        cyc(2);
        `CHK("k28.5", {1'b1, CHAR_K28_5}, {lane_is_k, lane_octet})
        wr(8'h03, {PAT_RANDOM, 5'h14});
        cyc(2);
        `CHK("flip", 1'b1, rd_flip)
        idx = 0;
        for (int i = 0; i < 12; i++) begin
            if (RPAT_EXP[95 - 8 * i -: 8] === lane_octet) begin
                idx = i;
            end
        end
        for (int j = 1; j < 12; j++) begin
            cyc(1);
            `CHK("random", RPAT_EXP[95 - 8 * ((idx + j) % 12) -: 8], lane_octet)
        end
        wr(8'h03, {PAT_ILA_LOOP, 5'h04});
        wait_ila(1'b1, hit);
        wait_ila(1'b0, hit);
        wait_ila(1'b1, hit);
        `CHK("ila repeats", 1'b1, hit)
        wr(8'h03, 8'h04);
        wait_data;
        `CHK("normal data", {1'b0, data_octet}, {lane_is_k, lane_octet})
    endtask

    task automatic t_ramp;
        wr(8'h02, 8'h0C);
        // multiframe clear held too, so the frame counter stays at zero
        wr(8'h03, 8'h0D);
        cyc(2);
        for (int j = 0; j < 4; j++) begin
            prev = lane_octet;
            cyc(1);
            `CHK("ramp", prev + 8'h01, lane_octet)
        end
        // clock enable low must freeze the ramp and the lane
        prev = lane_octet;
        ce = 1'b0;
        cyc(3);
        `CHK("frozen", prev, lane_octet)
        ce = 1'b1;
        cyc(1);
        `CHK("resumed", prev + 8'h01, lane_octet)
        wr(8'h02, 8'h00);
        cyc(2);
        `CHK("ramp in 14-bit", {1'b0, data_octet}, {lane_is_k, lane_octet})
        wr(8'h03, 8'h04);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        hold = 1'b0;
        frame_tick = 1'b0;
        mf_end = 1'b0;
        frame_phase = 2'h0;
        tick_idx = 0;
        data_octet = 8'h00;
        fails = 0;
        checked = 0;
        cyc(4);
        i_rst = 1'b0;
        t_regs;
        for (int d = 0; d < 4; d++) begin
            t_align(d[1:0]);
        end
        t_override;
        t_patterns;
        t_ramp;
        give_verdict;
    end

    // the scenarios need a few thousand cycles at most
    initial begin
        repeat (20000) @(negedge i_core_clk);
        fails++;
        give_verdict;
    end
endmodule
